// ### tcc_timer.sv
// 16-bit timer core: modes, clock select, capture with filter, force strobes,
// byte-paired counter and capture access, interrupt status, Avalon-MM slave.
// Assumes compare values and the waveform output stage live in same-clock logic.
// Operation
// - Mode 11 phase-correct PWM, TOP compare A; mode 12 clear-on-match, TOP capture.
// - Modes 14 and 15 fast PWM, TOP capture or compare A.
// - Four mode bits select sequence, TOP source and waveform family.
// - Filter passes a capture level after four equal successive samples.
// - Edge select zero means falling edge, one means rising edge.
// - Capture copies the counter into the capture register and sets the flag.
// - Capture is disabled whenever the capture register serves as TOP.
// - Clock select zero stops; one to five divide by 1, 8, 64, 256, 1024.
// - Clock select six counts external falling edges, seven rising edges.
// - Force bits strobe an immediate compare match, only in non-PWM modes.
// - A forced match raises no interrupt and clears no counter.
// - Force bits always read back as zero.
// - Sixteen-bit values pass their high byte through one shared temporary byte.
// - Low byte at base offset, high byte at base plus one.
// - A counter write blocks compare matches on the next timer tick.
// - Control B holds filter, edge, upper mode bits and clock select.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
	import tcc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [9:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        capture_pin_i,
	input  wire logic        external_count_pin_i,
	input  wire logic [15:0] compare_value_a_i,
	input  wire logic [15:0] compare_value_b_i,
	output logic      [3:0]  wave_mode_sel_o,
	output logic      [15:0] counter_value_o,
	output logic             count_down_o,
	output logic             compare_update_o,
	output logic             match_a_o,
	output logic             match_b_o,
	output logic             force_match_a_o,
	output logic             force_match_b_o,
	output logic             irq_o
);
	// Decodes the four mode bits into a counting family and TOP source.
	function automatic tcc_mode_type decode_mode(input logic [3:0] m);
		tcc_mode_type r;
		r = '{fam: FAM_NORMAL, top: TOP_MAX};
		case (m)
			4'd1: r = '{fam: FAM_PHASE, top: TOP_FF};
			4'd2: r = '{fam: FAM_PHASE, top: TOP_1FF};
			4'd3: r = '{fam: FAM_PHASE, top: TOP_3FF};
			4'd4: r = '{fam: FAM_CLEAR, top: TOP_CMPA};
			4'd5: r = '{fam: FAM_FAST, top: TOP_FF};
			4'd6: r = '{fam: FAM_FAST, top: TOP_1FF};
			4'd7: r = '{fam: FAM_FAST, top: TOP_3FF};
			4'd8: r = '{fam: FAM_PFC, top: TOP_CAP};
			4'd9: r = '{fam: FAM_PFC, top: TOP_CMPA};
			4'd10: r = '{fam: FAM_PHASE, top: TOP_CAP};
			4'd11: r = '{fam: FAM_PHASE, top: TOP_CMPA};
			4'd12: r = '{fam: FAM_CLEAR, top: TOP_CAP};
			4'd13: r = '{fam: FAM_RSVD, top: TOP_MAX};
			4'd14: r = '{fam: FAM_FAST, top: TOP_CAP};
			4'd15: r = '{fam: FAM_FAST, top: TOP_CMPA};
			default: r = '{fam: FAM_NORMAL, top: TOP_MAX};
		endcase
		return r;
	endfunction

	logic [1:0] rst_sync_q;
	logic       rst_n;
	// Releases the reset through two flip-flops.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	logic [7:0]  ctrl_a_q, ctrl_b_q, temp_q;
	logic [15:0] cnt_q, cap_q;
	logic [3:0]  irq_stat_q, irq_en_q;
	logic        dir_down_q, block_q, ack_q;
	logic [3:0]  mode;
	tcc_mode_type md;
	logic [15:0] top_val;
	logic        acc, wr_en, rd_en, tick, non_pwm, cap_disabled;
	logic [7:0]  idx;

	// Bus access decode; the answer comes one cycle after the request.
	assign acc               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = acc & ~ack_q;
	assign idx               = avs_address_i[9:2];
	assign wr_en             = avs_write_i & ack_q & avs_byteenable_i[0];
	assign rd_en             = avs_read_i & ack_q;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc & ~ack_q;
		end
	end

	assign mode    = {ctrl_b_q[BIT_MODE3], ctrl_b_q[BIT_MODE2], ctrl_a_q[1:0]};
	assign md      = decode_mode(mode);
	assign non_pwm = (md.fam == FAM_NORMAL) || (md.fam == FAM_CLEAR);
	assign cap_disabled = (md.top == TOP_CAP);

	always_comb begin
		case (md.top)
			TOP_FF:   top_val = 16'h00FF;
			TOP_1FF:  top_val = 16'h01FF;
			TOP_3FF:  top_val = 16'h03FF;
			TOP_CMPA: top_val = compare_value_a_i;
			TOP_CAP:  top_val = cap_q;
			default:  top_val = MAX_VAL;
		endcase
	end

	// Control registers keep only defined bits: A bits 1:0, B all but bit 5.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_q <= RST_BYTE;
			ctrl_b_q <= RST_BYTE;
			irq_en_q <= 4'h0;
		end else if (wr_en) begin
			if (idx == IDX_CTRL_A) ctrl_a_q <= {6'd0, avs_writedata_i[1:0]};
			if (idx == IDX_CTRL_B) ctrl_b_q <= avs_writedata_i[7:0] & 8'hDF;
			if (idx == IDX_IRQ_EN) irq_en_q <= avs_writedata_i[3:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			temp_q <= RST_BYTE;
		end else if (wr_en && (idx == IDX_CNT_HI || idx == IDX_CAP_HI)) begin
			temp_q <= avs_writedata_i[7:0];
		end else if (rd_en && idx == IDX_CNT_LO) begin
			temp_q <= cnt_q[15:8];
		end else if (rd_en && idx == IDX_CAP_LO) begin
			temp_q <= cap_q[15:8];
		end
	end

	// Prescaler and external pin synchroniser.
	logic [9:0] pre_q;
	logic [2:0] ext_q;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 10'd0;
			ext_q <= 3'b000;
		end else begin
			pre_q <= pre_q + 10'd1;
			ext_q <= {ext_q[1:0], external_count_pin_i};
		end
	end
	always_comb begin
		case (ctrl_b_q[2:0])
			3'd1: tick = 1'b1;
			3'd2: tick = &pre_q[TAP_8-1:0];
			3'd3: tick = &pre_q[TAP_64-1:0];
			3'd4: tick = &pre_q[TAP_256-1:0];
			3'd5: tick = &pre_q[TAP_1024-1:0];
			3'd6: tick = ext_q[2] & ~ext_q[1];
			3'd7: tick = ~ext_q[2] & ext_q[1];
			default: tick = 1'b0;
		endcase
	end

	// Counter sequencing, events and software writes.
	logic at_top, at_bot, wr_cnt, ovf_ev, cap_ev, mt_a, mt_b;
	assign at_top = (cnt_q == top_val);
	assign at_bot = (cnt_q == RST_WORD);
	assign wr_cnt = wr_en && (idx == IDX_CNT_LO);
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q      <= RST_WORD;
			dir_down_q <= 1'b0;
		end else begin
			// Single-slope families count up only; a down direction left over
			// from a dual-slope mode would otherwise linger on count_down_o.
			if (md.fam != FAM_PHASE && md.fam != FAM_PFC) begin
				dir_down_q <= 1'b0;
			end
			if (wr_cnt) begin
				cnt_q <= {temp_q, avs_writedata_i[7:0]};
			end else if (tick) begin
				case (md.fam)
					FAM_CLEAR, FAM_FAST: cnt_q <= at_top ? RST_WORD : cnt_q + 16'd1;
					FAM_PHASE, FAM_PFC: begin
						if (!dir_down_q && cnt_q >= top_val) begin
							dir_down_q <= 1'b1;
							cnt_q      <= cnt_q - 16'd1;
						end else if (dir_down_q && at_bot) begin
							dir_down_q <= 1'b0;
							cnt_q      <= cnt_q + 16'd1;
						end else begin
							cnt_q <= dir_down_q ? cnt_q - 16'd1 : cnt_q + 16'd1;
						end
					end
					default: cnt_q <= cnt_q + 16'd1;
				endcase
			end
		end
	end

	always_comb begin
		case (md.fam)
			FAM_FAST: begin
				ovf_ev           = tick & at_top;
				compare_update_o = tick & at_bot;
			end
			FAM_PHASE: begin
				ovf_ev           = tick & at_bot & dir_down_q;
				compare_update_o = tick & at_top & ~dir_down_q;
			end
			FAM_PFC: begin
				ovf_ev           = tick & at_bot & dir_down_q;
				compare_update_o = ovf_ev;
			end
			default: begin
				ovf_ev           = tick & (cnt_q == MAX_VAL);
				compare_update_o = 1'b0;
			end
		endcase
	end

	// match blocking after a counter write
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end
	assign mt_a      = tick & ~block_q & (cnt_q == compare_value_a_i);
	assign mt_b      = tick & ~block_q & (cnt_q == compare_value_b_i);
	assign match_a_o = mt_a;
	assign match_b_o = mt_b;

	// force strobes bypass flags and counter
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			force_match_a_o <= 1'b0;
			force_match_b_o <= 1'b0;
		end else begin
			force_match_a_o <= wr_en && idx == IDX_CTRL_C && non_pwm
				&& avs_writedata_i[BIT_FORCE_A];
			force_match_b_o <= wr_en && idx == IDX_CTRL_C && non_pwm
				&& avs_writedata_i[BIT_FORCE_B];
		end
	end

	// Capture pin synchroniser and four-sample filter.
	logic [1:0]          cp_sync_q;
	logic [FILT_LEN-1:0] filt_sh_q;
	logic                filt_q, sel_q, sel_d;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cp_sync_q <= 2'b00;
			filt_sh_q <= '0;
			filt_q    <= 1'b0;
			sel_q     <= 1'b0;
		end else begin
			cp_sync_q <= {cp_sync_q[0], capture_pin_i};
			filt_sh_q <= {filt_sh_q[FILT_LEN-2:0], cp_sync_q[1]};
			if (&filt_sh_q) filt_q <= 1'b1;
			else if (~|filt_sh_q) filt_q <= 1'b0;
			sel_q <= sel_d;
		end
	end
	assign sel_d = ctrl_b_q[BIT_FILT_EN] ? filt_q : cp_sync_q[1];
	assign cap_ev = ~cap_disabled & (ctrl_b_q[BIT_EDGE_SEL] ? (sel_d & ~sel_q)
		: (~sel_d & sel_q));

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cap_q <= RST_WORD;
		end else if (cap_ev) begin
			cap_q <= cnt_q;
		end else if (wr_en && idx == IDX_CAP_LO) begin
			cap_q <= {temp_q, avs_writedata_i[7:0]};
		end
	end

	// Sticky status; a set in the clearing cycle wins.
	logic [3:0] ev_vec, clr_vec;
	assign ev_vec  = {mt_b, mt_a, ovf_ev, cap_ev};
	assign clr_vec = (wr_en && idx == IDX_IRQ_CLR) ? avs_writedata_i[3:0] : 4'h0;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= 4'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr_vec) | ev_vec;
		end
	end
	assign irq_o = |(irq_stat_q & irq_en_q);

	// Read data mux; force bits read zero, byte placement.
	logic [7:0] rd_byte;
	always_comb begin
		case (idx)
			IDX_CTRL_A:   rd_byte = ctrl_a_q;
			IDX_CTRL_B:   rd_byte = ctrl_b_q;
			IDX_CTRL_C:   rd_byte = RST_BYTE;
			IDX_CNT_LO:   rd_byte = cnt_q[7:0];
			IDX_CNT_HI:   rd_byte = temp_q;
			IDX_CAP_LO:   rd_byte = cap_q[7:0];
			IDX_CAP_HI:   rd_byte = temp_q;
			IDX_IRQ_STAT: rd_byte = {4'h0, irq_stat_q};
			IDX_IRQ_EN:   rd_byte = {4'h0, irq_en_q};
			default:      rd_byte = RST_BYTE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !ack_q) begin
			avs_readdata_o <= {24'h00_0000, rd_byte};
		end
	end

	assign wave_mode_sel_o = mode;
	assign counter_value_o = cnt_q;
	assign count_down_o    = dir_down_q;

	// Checks on the logic above.
	cap_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		cap_ev |=> (cap_q == $past(cnt_q)) && irq_stat_q[IRQ_CAPTURE])
		else $error("capture did not copy counter or set flag");
	cap_off_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		cap_disabled |-> !cap_ev) else $error("capture fired while used as TOP");
	edge_rise_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		cap_ev && ctrl_b_q[BIT_EDGE_SEL] |-> sel_d && !sel_q)
		else $error("rising capture without rising edge");
	filt_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		$rose(filt_q) |-> $past(filt_sh_q) == 4'hF) else $error("filter changed early");
	stop_cnt_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		ctrl_b_q[2:0] == 3'd0 && !wr_cnt |=> cnt_q == $past(cnt_q))
		else $error("counter moved while stopped");
	blk_match_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_cnt |=> !match_a_o && !match_b_o) else $error("match after counter write");
	force_pwm_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		force_match_a_o |-> $past(non_pwm)) else $error("force strobe in PWM mode");
	force_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		force_match_a_o && !$past(mt_a) && !$past(clr_vec[IRQ_MATCH_A])
		|-> irq_stat_q[IRQ_MATCH_A] == $past(irq_stat_q[IRQ_MATCH_A]))
		else $error("force strobe raised a flag");
	force_read_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		avs_read_i && !ack_q && idx == IDX_CTRL_C |=> avs_readdata_o == 32'h0000_0000)
		else $error("force bits read nonzero");
	fast_top_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		md.fam == FAM_FAST && tick && at_top && !wr_cnt |=> cnt_q == RST_WORD)
		else $error("fast PWM did not wrap at TOP");
endmodule
`default_nettype wire

// ### tcc_pkg.sv
// Package for the 16-bit timer control block: register map, fields, resets.
// Assumes a single 200 MHz clock and an Avalon-MM slave with byte addresses.
package tcc_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CTRL_A   = 8'hA0;
	localparam logic [7:0] IDX_CTRL_B   = 8'hA1;
	localparam logic [7:0] IDX_CTRL_C   = 8'hA2;
	localparam logic [7:0] IDX_CNT_LO   = 8'hA4;
	localparam logic [7:0] IDX_CNT_HI   = 8'hA5;
	localparam logic [7:0] IDX_CAP_LO   = 8'hA6;
	localparam logic [7:0] IDX_CAP_HI   = 8'hA7;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hB0;
	localparam logic [7:0] IDX_IRQ_EN   = 8'hB1;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'hB2;
	// Field positions of the second control register.
	localparam int BIT_FILT_EN  = 7;
	localparam int BIT_EDGE_SEL = 6;
	localparam int BIT_MODE3    = 4;
	localparam int BIT_MODE2    = 3;
	// Field positions of the force register.
	localparam int BIT_FORCE_A  = 7;
	localparam int BIT_FORCE_B  = 6;
	// Interrupt status layout.
	localparam int IRQ_CAPTURE  = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_MATCH_A  = 2;
	localparam int IRQ_MATCH_B  = 3;
	// Reset values and the counter maximum.
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] MAX_VAL  = 16'hFFFF;
	// Capture filter length in samples.
	localparam int FILT_LEN = 4;
	// Prescaler taps for divide by 8, 64, 256 and 1024.
	localparam int TAP_8    = 3;
	localparam int TAP_64   = 6;
	localparam int TAP_256  = 8;
	localparam int TAP_1024 = 10;
	// Counting families and sources of TOP.
	typedef enum logic [2:0] {FAM_NORMAL, FAM_CLEAR, FAM_FAST, FAM_PHASE, FAM_PFC, FAM_RSVD}
		tcc_fam_type;
	typedef enum logic [2:0] {TOP_MAX, TOP_FF, TOP_1FF, TOP_3FF, TOP_CMPA, TOP_CAP} tcc_top_type;
	typedef struct packed {
		tcc_fam_type fam;
		tcc_top_type top;
	} tcc_mode_type;
endpackage

// ### tcc_pins_model.sv
// Model of the far side of the timer: the capture pin and the external count pin.
// Assumes the bench calls its tasks from one process and that clk_i is the timer clock.
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
	input  wire logic clk_i,
	output logic      capture_pin_o,
	output logic      external_count_pin_o
);
	// Both pins start from a known idle level.
	initial begin
		capture_pin_o = 1'b1;
		external_count_pin_o = 1'b0;
	end
	task automatic cap_level(input logic lvl, input int n);
		@(posedge clk_i);
		capture_pin_o <= lvl;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic ext_level(input logic lvl);
		@(posedge clk_i);
		external_count_pin_o <= lvl;
		repeat (8) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ### tcc_tb.sv
// Self-checking bench for the timer: register access, counting, capture and strobes.
// Assumes the timer package and a far-side pin model compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tcc_pkg::*;
	logic        clk_i;
	logic        rst_b_i;
	logic [9:0]  adr;
	logic        rd_en;
	logic        wr_en;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wait_req;
	logic        cap_pin;
	logic        ext_pin;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic [3:0]  mode_sel;
	logic [15:0] cnt;
	logic        cnt_down;
	logic        m_a;
	logic        m_b;
	logic        f_a;
	logic        f_b;
	logic        irq;
	logic        cmp_upd;
	logic [7:0]  b;
	logic [15:0] v;
	int          n_mismatch;
	int          comparisons;
	int          cycles;
	int          k;
	int          divs [5] = '{1, 8, 64, 256, 1024};

	tcc_pins_model pins (.clk_i(clk_i), .capture_pin_o(cap_pin), .external_count_pin_o(ext_pin));
	tcc_timer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .capture_pin_i(cap_pin),
		.external_count_pin_i(ext_pin), .compare_value_a_i(cmp_a), .compare_value_b_i(cmp_b),
		.wave_mode_sel_o(mode_sel), .counter_value_o(cnt), .count_down_o(cnt_down),
		.compare_update_o(cmp_upd), .match_a_o(m_a), .match_b_o(m_b), .force_match_a_o(f_a),
		.force_match_b_o(f_b), .irq_o(irq));

	// Free-running clock at 200 MHz.
	always #2.5 clk_i = ~clk_i;
	// Cuts a hang short and reports it as a mismatch.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 40000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		adr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		rd_en <= ~w;
		wr_en <= w;
		do @(posedge clk_i); while (wait_req !== 1'b0);
		b = rdata[7:0];
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk({8'h00, b}, {8'h00, exp});
	endtask
	// Sixteen-bit values go high byte first on writes, low byte first on reads.
	task automatic wr16(input logic [7:0] idx, input logic [15:0] d);
		wr(idx + 8'h01, d[15:8]);
		wr(idx, d[7:0]);
	endtask
	task automatic rd16(input logic [7:0] idx, input logic [15:0] exp);
		rdc(idx, exp[7:0]);
		rdc(idx + 8'h01, exp[15:8]);
	endtask
	// no caller ever programs the reserved mode 13.
	task automatic cfg(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] fe);
		wr(IDX_CTRL_A, {6'h00, m[1:0]});
		wr(IDX_CTRL_B, {fe, 1'b0, m[3:2], cs});
	endtask
	// Runs one counting mode briefly and checks its peak, direction and overflow flag.
	task automatic run_mode(input logic [3:0] m, input logic [15:0] top, input logic ovf);
		logic [15:0] mx;
		logic [15:0] up;
		logic        dn;
		int          nu;
		mx = 16'h0000;
		up = 16'h0000;
		dn = 1'b0;
		nu = 0;
		cmp_a <= 16'h0005;
		wr16(IDX_CAP_LO, 16'h0007);
		cfg(m, 3'h0, 2'b00);
		wr16(IDX_CNT_LO, 16'h0000);
		wr(IDX_IRQ_CLR, 8'h0F);
		cfg(m, 3'h1, 2'b00);
		repeat (40) begin
			@(negedge clk_i);
			if (cnt > mx) mx = cnt;
			dn = dn | cnt_down;
			if (cmp_upd) begin
				up = cnt;
				nu++;
			end
		end
		cfg(m, 3'h0, 2'b00);
		chk({15'h0000, nu != 0}, {15'h0000, m != 4'hC}); // buffer update seen
		chk(up, (m == 4'hB) ? top : 16'h0000); // buffer update point
		chk(mx, top);
		chk({15'h0000, dn}, {15'h0000, m == 4'hB});
		bus(1'b0, IDX_IRQ_STAT, 8'h00);
		chk({15'h0000, b[IRQ_OVERFLOW]}, {15'h0000, ovf});
	endtask

	// Main sequence.
	initial begin
		clk_i = 1'b0;
		rst_b_i = 1'b0;
		{adr, rd_en, wr_en, wdata, cmp_a, cmp_b} = '0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdc(IDX_CTRL_B, 8'h00); // reset value
		rdc(IDX_CTRL_C, 8'h00); // reset value
		rd16(IDX_CNT_LO, RST_WORD); // reset value
		rd16(IDX_CAP_LO, RST_WORD); // reset value
		rdc(8'hA3, 8'h00);
		wr(IDX_CTRL_B, 8'hF8);
		rdc(IDX_CTRL_B, 8'hD8); // field layout
		chk({12'h000, mode_sel}, 16'h000C); // upper mode bits
		cfg(4'h0, 3'h0, 2'b00);
		wr16(IDX_CNT_LO, 16'h1234);
		@(negedge clk_i);
		chk(cnt, 16'h1234); // paired write
		rd16(IDX_CNT_LO, 16'h1234); // byte offsets
		wr(IDX_CNT_HI, 8'h56);
		wr(IDX_CAP_LO, 8'h78);
		rd16(IDX_CAP_LO, 16'h5678); // shared high byte
		for (k = 0; k < 5; k++) begin
			cfg(4'h0, 3'(k + 1), 2'b00);
			@(negedge clk_i);
			v = cnt;
			repeat (10 * divs[k]) @(negedge clk_i);
			chk(cnt - v, 16'h000A); // prescaler ratio
		end
		cfg(4'h0, 3'h0, 2'b00);
		@(negedge clk_i);
		v = cnt;
		repeat (20) @(negedge clk_i);
		chk(cnt - v, 16'h0000); // stopped
		cfg(4'h0, 3'h7, 2'b00);
		@(negedge clk_i);
		v = cnt;
		pins.ext_level(1'b1);
		@(negedge clk_i);
		chk(cnt - v, 16'h0001); // rising counts
		pins.ext_level(1'b0);
		@(negedge clk_i);
		chk(cnt - v, 16'h0001); // falling ignored
		cfg(4'h0, 3'h6, 2'b00);
		@(negedge clk_i);
		v = cnt;
		pins.ext_level(1'b1);
		pins.ext_level(1'b0);
		@(negedge clk_i);
		chk(cnt - v, 16'h0001); // falling counts
		cfg(4'h0, 3'h0, 2'b00);
		wr(IDX_IRQ_EN, 8'h01);
		wr16(IDX_CNT_LO, 16'h1111);
		wr(IDX_IRQ_CLR, 8'h0F);
		pins.cap_level(1'b0, 8);
		rd16(IDX_CAP_LO, 16'h1111); // falling capture
		chk({15'h0000, irq}, 16'h0001); // capture interrupt
		wr(IDX_IRQ_CLR, 8'h01);
		@(negedge clk_i);
		chk({15'h0000, irq}, 16'h0000); // flag cleared
		wr16(IDX_CNT_LO, 16'h2222);
		pins.cap_level(1'b1, 8);
		rd16(IDX_CAP_LO, 16'h1111); // rising ignored
		cfg(4'h0, 3'h0, 2'b01);
		wr16(IDX_CNT_LO, 16'h3333);
		pins.cap_level(1'b0, 8);
		pins.cap_level(1'b1, 8);
		rd16(IDX_CAP_LO, 16'h3333); // rising capture
		cfg(4'h0, 3'h0, 2'b11);
		pins.cap_level(1'b0, 8);
		wr16(IDX_CNT_LO, 16'h4444);
		pins.cap_level(1'b1, 2);
		pins.cap_level(1'b0, 8);
		rd16(IDX_CAP_LO, 16'h3333); // short pulse filtered
		pins.cap_level(1'b1, 12);
		rd16(IDX_CAP_LO, 16'h4444); // steady level passes
		wr(IDX_IRQ_EN, 8'h00);
		@(negedge clk_i);
		chk({15'h0000, irq}, 16'h0000); // masked interrupt
		rdc(IDX_IRQ_STAT, 8'h01); // sticky flag
		cfg(4'hC, 3'h0, 2'b01);
		wr(IDX_IRQ_CLR, 8'h0F);
		pins.cap_level(1'b0, 8);
		pins.cap_level(1'b1, 8);
		rd16(IDX_CAP_LO, 16'h4444); // capture off
		rdc(IDX_IRQ_STAT, 8'h00); // no capture flag
		cfg(4'h0, 3'h0, 2'b00);
		wr(IDX_CTRL_C, 8'hC0);
		@(negedge clk_i);
		chk({14'h0000, f_a, f_b}, 16'h0003); // force strobes
		@(negedge clk_i);
		chk({14'h0000, f_a, f_b}, 16'h0000); // single pulse
		rdc(IDX_CTRL_C, 8'h00); // reads zero
		rdc(IDX_IRQ_STAT, 8'h00); // no interrupt
		cfg(4'h4, 3'h0, 2'b00);
		wr16(IDX_CNT_LO, 16'h0077);
		wr(IDX_CTRL_C, 8'h80);
		rd16(IDX_CNT_LO, 16'h0077); // no counter clear
		cfg(4'hF, 3'h0, 2'b00);
		wr(IDX_CTRL_C, 8'hC0);
		@(negedge clk_i);
		chk({14'h0000, f_a, f_b}, 16'h0000); // no force in PWM
		@(posedge clk_i);
		cmp_a <= 16'h0100;
		cmp_b <= 16'h0100;
		cfg(4'h0, 3'h1, 2'b00);
		wr(IDX_IRQ_CLR, 8'h0F);
		// the counter is written while running, so only the blocked tick is judged.
		wr16(IDX_CNT_LO, 16'h0100);
		k = 0;
		repeat (8) begin
			@(negedge clk_i);
			k += m_a + m_b;
		end
		chk(k[15:0], 16'h0000); // match blocked
		wr16(IDX_CNT_LO, 16'h00FE);
		k = 0;
		repeat (8) begin
			@(negedge clk_i);
			k += m_a + m_b;
		end
		chk(k[15:0], 16'h0002); // later match kept
		rdc(IDX_IRQ_STAT, 8'h0C); // match flags set
		run_mode(4'hB, 16'h0005, 1'b1); // mode eleven
		run_mode(4'hC, 16'h0007, 1'b0); // mode twelve
		run_mode(4'hE, 16'h0007, 1'b1); // mode fourteen
		run_mode(4'hF, 16'h0005, 1'b1); // mode fifteen
		complete_run();
	end
endmodule
`default_nettype wire
